// >>> rtl/accr_regs.sv
// per-channel configuration registers: ch1 gain/phase trim, ch2 input setup and gain
// assumes the control-port decoder gives one-cycle byte write/read strobes on mclk
// assumes the modulator tick and sample come from logic already on mclk
// assumes the shared level-control selector is a register bit on mclk
// design notes
// - every stored setting comes straight from a flop, derived ones decode flops and the selector, so downstream logic never sees a half-written byte.
// - a read answers one cycle after its strobe, with reg_hit beside it, and both drop back the cycle after.
// - a read and a write of one register in the same cycle return the value from before the write.
// - unmapped addresses and foreign pages are ignored on write and read back as zero with no hit.
// - reserved field codes are dropped one field at a time; the rest of the byte still lands.
// - the gain register refuses codes above the top step instead of clamping them.
// - reserved bits are never stored, so they cannot leak back on a read.
// - the gain trim output in tenths is derived from the code; only the code is stored.
// - the phase delay line is 256 flops wide; only the first 255 positions are tapped.
// - a zero phase trim still registers the live input once per tick, so output timing stays on the tick.
// - the delay line keeps its contents across trim changes, so a new trim uses history at once.
// - the first ticks after reset read zeros out of the delay line until it has filled.
// - the delay line shifts only on mod_tick; between ticks the output holds.
// - coupling is stored as written but only reported as dc for the analog sources.
// - the level-control enable is stored here; which of the two it drives comes from the shared selector.
// - the impedance and kind settings are stored for the front end and not interpreted here.
// - synchronous reset takes priority over any access presented in the same cycle.
// - general-purpose pin setup around a source change is left to the host and not checked here.
// - every register, including the 256-bit delay line, runs on every rising mclk edge; the tick only gates data.
// - the read mux is a plain priority chain; the selects are one-hot by construction.
// - the address decode is shared between the read path and the write strobes.
`timescale 1ns/1ps
module accr_regs #(
    parameter int PHASE_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port from the control-port decoder
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // shared level-control selector, bit 3 of the shared config register
    input wire logic shared_level_select,
    // modulator-rate sample path of channel 1
    input wire logic mod_tick,
    input wire logic ch1_sample_in,
    output logic ch1_sample_out,
    // decoded settings
    output logic [3:0] ch1_gain_trim_code,
    output logic signed [7:0] ch1_gain_trim_tenths,
    output logic [7:0] ch1_phase_delay_code,
    output logic ch2_input_kind,
    output logic [1:0] ch2_source_select,
    output logic ch2_coupling_select,
    output logic ch2_is_analog,
    output logic ch2_coupling_select_coupled,
    output logic [1:0] ch2_impedance_select,
    output logic ch2_range_boost_enable,
    output logic ch2_range_enhancer_on,
    output logic ch2_auto_level_on,
    output logic [5:0] ch2_analog_gain_code
);
    // elaboration check: the delay line and read path are built for an 8-bit phase trim
    if (PHASE_W != 8) begin : g_bad_phase_w
        $error("accr_regs: phase trim width must be 8");
    end

    // all state in one struct
    typedef struct packed {
        // channel 1 trims
        logic [3:0] gain_trim;
        logic [7:0] phase;
        // channel 2 input setup
        logic kind;
        logic [1:0] source;
        logic coupling;
        logic [1:0] imped;
        logic boost;
        // channel 2 analog gain
        logic [5:0] again;
        // read answer
        logic [7:0] rdata;
        logic hit;
        // channel 1 phase delay line and its output flop
        logic [255:0] dline;
        logic sample;
    } accr_state_t;

    accr_state_t st_q;
    accr_state_t st_d;

    // state after reset: trim code 8, everything else zero
    function automatic accr_state_t accr_reset_state();
        accr_state_t rs;
        rs = '0;
        rs.gain_trim = accr_pkg::ACCR_RST_GAIN_TRIM;
        rs.phase = accr_pkg::ACCR_RST_PHASE_TRIM;
        rs.kind = accr_pkg::ACCR_RST_INPUT_SETUP[accr_pkg::ACCR_POS_KIND];
        rs.source = accr_pkg::ACCR_RST_INPUT_SETUP[accr_pkg::ACCR_POS_SOURCE +: 2];
        rs.coupling = accr_pkg::ACCR_RST_INPUT_SETUP[accr_pkg::ACCR_POS_COUPLING];
        rs.imped = accr_pkg::ACCR_RST_INPUT_SETUP[accr_pkg::ACCR_POS_IMPEDANCE +: 2];
        rs.boost = accr_pkg::ACCR_RST_INPUT_SETUP[accr_pkg::ACCR_POS_BOOST];
        rs.again = accr_pkg::ACCR_RST_ANALOG_GAIN;
        accr_reset_state = rs;
    endfunction : accr_reset_state

    // trim code to signed tenths of a dB: code 0 is the bottom step, one tenth per code
    function automatic logic signed [7:0] accr_trim_tenths(input logic [3:0] code);
        accr_trim_tenths = 8'(accr_pkg::ACCR_TRIM_BASE_TENTHS + int'(code));
    endfunction : accr_trim_tenths

    // decode a page-0 address match
    function automatic logic accr_match(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] ofs);
        accr_match = (pg == accr_pkg::ACCR_PAGE) && (ad == ofs);
    endfunction : accr_match

    // pull a two-bit field out of a written byte
    function automatic logic [1:0] accr_field2(input logic [7:0] data, input int pos);
        accr_field2 = data[pos +: 2];
    endfunction : accr_field2

    // keep the old two-bit code when the written one is reserved
    function automatic logic [1:0] accr_keep_code(input logic [1:0] old_code, input logic [1:0] new_code,
            input logic [1:0] rsvd_code);
        if (new_code == rsvd_code) begin
            accr_keep_code = old_code;
        end else begin
            accr_keep_code = new_code;
        end
    endfunction : accr_keep_code

    // true for the two analog source codes
    function automatic logic accr_is_analog(input logic [1:0] src);
        accr_is_analog = (src == accr_pkg::ACCR_SRC_DIFF) || (src == accr_pkg::ACCR_SRC_SINGLE);
    endfunction : accr_is_analog

    // register selects
    logic sel_trim;
    logic sel_phase;
    logic sel_input;
    logic sel_gain;
    logic sel_any;
    // write strobes
    logic wr_trim;
    logic wr_phase;
    logic wr_input;
    logic wr_gain;
    // written fields
    logic [3:0] wd_trim;
    logic wd_kind;
    logic [1:0] wd_source;
    logic wd_coupling;
    logic [1:0] wd_imped;
    logic wd_boost;
    logic [5:0] wd_gain;
    logic wd_gain_ok;
    // per-register read bytes, read mux, delay line shift and tap
    logic [7:0] rd_trim;
    logic [7:0] rd_phase;
    logic [7:0] rd_input;
    logic [7:0] rd_gain;
    logic [7:0] rd_mux;
    logic [255:0] dline_next;
    logic tap_bit;

    // address decode
    assign sel_trim = accr_match(reg_page, reg_addr, accr_pkg::ACCR_OFS_CH1_GAIN_TRIM);
    assign sel_phase = accr_match(reg_page, reg_addr, accr_pkg::ACCR_OFS_CH1_PHASE_TRIM);
    assign sel_input = accr_match(reg_page, reg_addr, accr_pkg::ACCR_OFS_CH2_INPUT_SETUP);
    assign sel_gain = accr_match(reg_page, reg_addr, accr_pkg::ACCR_OFS_CH2_ANALOG_GAIN_CODE_SETTING);
    assign sel_any = sel_trim || sel_phase || sel_input || sel_gain;

    // a write only lands on a mapped register of page 0
    assign wr_trim = reg_wr && sel_trim;
    assign wr_phase = reg_wr && sel_phase;
    assign wr_input = reg_wr && sel_input;
    assign wr_gain = reg_wr && sel_gain;

    // fields of the written byte
    assign wd_trim = reg_wdata[accr_pkg::ACCR_POS_GAIN_TRIM +: 4];
    assign wd_kind = reg_wdata[accr_pkg::ACCR_POS_KIND];
    assign wd_source = accr_field2(reg_wdata, accr_pkg::ACCR_POS_SOURCE);
    assign wd_coupling = reg_wdata[accr_pkg::ACCR_POS_COUPLING];
    assign wd_imped = accr_field2(reg_wdata, accr_pkg::ACCR_POS_IMPEDANCE);
    assign wd_boost = reg_wdata[accr_pkg::ACCR_POS_BOOST];
    assign wd_gain = reg_wdata[accr_pkg::ACCR_POS_ANALOG_GAIN +: 6];
    assign wd_gain_ok = wd_gain <= accr_pkg::ACCR_GAIN_MAX;

    // per-register read bytes, reserved bits zero
    assign rd_trim = {st_q.gain_trim, 4'h0};
    assign rd_phase = st_q.phase;
    assign rd_input = {st_q.kind, st_q.source, st_q.coupling, st_q.imped, 1'b0, st_q.boost};
    assign rd_gain = {st_q.again, 2'h0};

    // read mux over the selected register
    always_comb begin
        rd_mux = 8'h00;
        if (sel_trim) begin
            rd_mux = rd_trim;
        end else if (sel_phase) begin
            rd_mux = rd_phase;
        end else if (sel_input) begin
            rd_mux = rd_input;
        end else if (sel_gain) begin
            rd_mux = rd_gain;
        end
    end

    // delay line shift: newest sample enters at position 0
    assign dline_next = {st_q.dline[254:0], ch1_sample_in};

    // delay line tap: zero takes the live input, n takes the bit shifted in n ticks back
    always_comb begin
        tap_bit = ch1_sample_in;
        if (st_q.phase != 8'h00) begin
            tap_bit = st_q.dline[st_q.phase - 8'h01];
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        // read answer for one cycle, zero and no hit off the map
        st_d.hit = reg_rd && sel_any;
        st_d.rdata = reg_rd ? rd_mux : 8'h00;
        // channel 1 trims
        if (wr_trim) begin
            st_d.gain_trim = wd_trim;
        end
        if (wr_phase) begin
            st_d.phase = reg_wdata;
        end
        // channel 2 input setup; a reserved code leaves only its own field alone
        if (wr_input) begin
            st_d.kind = wd_kind;
            st_d.source = accr_keep_code(st_q.source, wd_source, accr_pkg::ACCR_SRC_RSVD);
            st_d.coupling = wd_coupling;
            st_d.imped = accr_keep_code(st_q.imped, wd_imped, accr_pkg::ACCR_IMP_RSVD);
            st_d.boost = wd_boost;
        end
        // channel 2 analog gain; codes above the top step are dropped
        if (wr_gain && wd_gain_ok) begin
            st_d.again = wd_gain;
        end
        // phase delay line advances once per modulator tick
        if (mod_tick) begin
            st_d.dline = dline_next;
            st_d.sample = tap_bit;
        end
        // synchronous reset wins over any access in the same cycle
        if (srst) begin
            st_d = accr_reset_state();
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        st_q <= st_d;
    end

    // read answer and delayed sample
    assign reg_rdata = st_q.rdata;
    assign reg_hit = st_q.hit;
    assign ch1_sample_out = st_q.sample;

    // channel 1 trim settings
    assign ch1_gain_trim_code = st_q.gain_trim;
    assign ch1_gain_trim_tenths = accr_trim_tenths(st_q.gain_trim);
    assign ch1_phase_delay_code = st_q.phase;

    // channel 2 input setup as stored
    assign ch2_input_kind = st_q.kind;
    assign ch2_source_select = st_q.source;
    assign ch2_coupling_select = st_q.coupling;
    assign ch2_impedance_select = st_q.imped;
    assign ch2_range_boost_enable = st_q.boost;
    assign ch2_analog_gain_code = st_q.again;

    // derived channel 2 settings: coupling only counts for analog sources
    assign ch2_is_analog = accr_is_analog(st_q.source);
    assign ch2_coupling_select_coupled = ch2_is_analog && st_q.coupling;

    // range enhancer or level control, picked by the shared selector
    assign ch2_range_enhancer_on = st_q.boost && !shared_level_select;
    assign ch2_auto_level_on = st_q.boost && shared_level_select;
endmodule : accr_regs

// >>> rtl/accr_pkg.sv
// package for the per-channel configuration register slice
// assumes a byte-wide register port on page 0 driven by the control-port decoder
package accr_pkg;
    // register page and byte addresses
    localparam logic [7:0] ACCR_PAGE = 8'h00;
    localparam logic [7:0] ACCR_OFS_CH1_GAIN_TRIM = 8'h3f;
    localparam logic [7:0] ACCR_OFS_CH1_PHASE_TRIM = 8'h40;
    localparam logic [7:0] ACCR_OFS_CH2_INPUT_SETUP = 8'h41;
    localparam logic [7:0] ACCR_OFS_CH2_ANALOG_GAIN_CODE_SETTING = 8'h42;
    // reset values
    localparam logic [3:0] ACCR_RST_GAIN_TRIM = 4'h8;
    localparam logic [7:0] ACCR_RST_PHASE_TRIM = 8'h00;
    localparam logic [7:0] ACCR_RST_INPUT_SETUP = 8'h00;
    localparam logic [5:0] ACCR_RST_ANALOG_GAIN = 6'h00;
    // field positions
    localparam int ACCR_POS_GAIN_TRIM = 4;
    localparam int ACCR_POS_KIND = 7;
    localparam int ACCR_POS_SOURCE = 5;
    localparam int ACCR_POS_COUPLING = 4;
    localparam int ACCR_POS_IMPEDANCE = 2;
    localparam int ACCR_POS_BOOST = 0;
    localparam int ACCR_POS_ANALOG_GAIN = 2;
    // field codes
    localparam logic [1:0] ACCR_SRC_DIFF = 2'h0;
    localparam logic [1:0] ACCR_SRC_SINGLE = 2'h1;
    localparam logic [1:0] ACCR_SRC_PDM = 2'h2;
    localparam logic [1:0] ACCR_SRC_RSVD = 2'h3;
    localparam logic [1:0] ACCR_IMP_RSVD = 2'h3;
    localparam logic [5:0] ACCR_GAIN_MAX = 6'h2a;
    // gain trim: code 0 is -8 tenths of a dB, one tenth per step
    localparam int ACCR_TRIM_BASE_TENTHS = -8;
endpackage : accr_pkg

// >>> tb/accr_props.sv
// checker: timing and decode relations of the configuration register slice
// assumes it is bound onto accr_regs and sees only its ports
`timescale 1ns/1ps
module accr_props (
    // register port and single-bit settings
    input wire logic mclk, srst, reg_wr, reg_rd, reg_hit, shared_level_select, mod_tick, ch1_sample_in,
    input wire logic ch1_sample_out, ch2_coupling_select, ch2_coupling_select_coupled, ch2_range_boost_enable,
    input wire logic ch2_range_enhancer_on, ch2_auto_level_on,
    // wide settings
    input wire logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, ch1_phase_delay_code,
    input wire logic signed [7:0] ch1_gain_trim_tenths,
    input wire logic [3:0] ch1_gain_trim_code,
    input wire logic [1:0] ch2_source_select,
    input wire logic [5:0] ch2_analog_gain_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // page-0 write or read strobe at one byte address
    sequence s_wr(a); reg_wr && reg_page == 8'h00 && reg_addr == a; endsequence
    sequence s_rd(a); reg_rd && reg_page == 8'h00 && reg_addr == a; endsequence
    AST_RST: assert property ($fell(srst) |-> ch1_gain_trim_code == 4'h8 && ch1_phase_delay_code == 8'h00)
        else $error("reset values wrong");
    AST_TRIM: assert property (ch1_gain_trim_tenths == $signed({4'h0, ch1_gain_trim_code}) - 8'sh08)
        else $error("trim tenths wrong");
    AST_PHASE: assert property (s_wr(8'h40) |=> ch1_phase_delay_code == $past(reg_wdata))
        else $error("phase write lost");
    AST_DLY0: assert property (mod_tick && ch1_phase_delay_code == 8'h00 |=> ch1_sample_out == $past(ch1_sample_in))
        else $error("zero delay not direct");
    AST_PAGE: assert property (reg_rd && reg_page != 8'h00 |=> !reg_hit && reg_rdata == 8'h00)
        else $error("foreign page answered");
    AST_SRC: assert property (s_wr(8'h41) ##0 reg_wdata[6:5] == 2'h3 |=> $stable(ch2_source_select))
        else $error("reserved source taken");
    AST_DC: assert property (ch2_coupling_select_coupled == (ch2_coupling_select && ch2_source_select != 2'h2))
        else $error("coupling decode wrong");
    AST_LEVEL: assert property (ch2_range_enhancer_on == (ch2_range_boost_enable && !shared_level_select)
        && ch2_auto_level_on == (ch2_range_boost_enable && shared_level_select)) else $error("level decode wrong");
    AST_RDLOW: assert property (s_rd(8'h42) |=> reg_hit && reg_rdata[1:0] == 2'h0)
        else $error("gain low bits not zero");
    AST_GAIN: assert property (s_wr(8'h42) ##0 reg_wdata[7:2] > 6'h2a |=> $stable(ch2_analog_gain_code))
        else $error("reserved gain taken");
endmodule : accr_props
bind accr_regs accr_props accr_props_i (.*);

// >>> tb/accr_host.sv
// host model: drives the byte register port as the control-port decoder does
// assumes mclk from the bench; each access launched at a falling edge
`timescale 1ns/1ps
module accr_host (
    // clock
    input wire logic mclk,
    // register port
    output logic [7:0] reg_page, reg_addr, reg_wdata,
    output logic reg_wr, reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    initial {reg_wr, reg_rd, reg_page, reg_addr, reg_wdata} = 26'h0;
    // one access held across one rising edge; pin setup before a source change is not modelled
    task automatic acc(input logic w, input logic [7:0] p, a, d, output logic [7:0] q, output logic h);
        @(negedge mclk);
        {reg_wr, reg_rd, reg_page, reg_addr, reg_wdata} = {w, !w, p, a, d};
        @(negedge mclk);
        q = reg_rdata;
        h = reg_hit;
        {reg_wr, reg_rd, reg_page, reg_addr, reg_wdata} = {2'h0, ~p, ~a, ~d};
    endtask : acc
endmodule : accr_host

// >>> tb/testbench.sv
// testbench: random register traffic and sample delay checked against a bench model
// assumes accr_pkg, accr_regs, accr_host and accr_props compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module testbench;
    logic mclk = 0, srst = 1, shared_level_select = 0, mod_tick = 0, ch1_sample_in = 0, chk = 0, exp_out, h;
    logic reg_wr, reg_rd, reg_hit, ch1_sample_out, ch2_input_kind, ch2_coupling_select, ch2_is_analog;
    logic ch2_coupling_select_coupled, ch2_range_boost_enable, ch2_range_enhancer_on, ch2_auto_level_on;
    logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, ch1_phase_delay_code, q;
    logic signed [7:0] ch1_gain_trim_tenths;
    logic [3:0] ch1_gain_trim_code;
    logic [1:0] ch2_source_select, ch2_impedance_select;
    logic [5:0] ch2_analog_gain_code;
    logic [7:0] m [63:66];
    logic [255:0] hist;
    int seed = 32'h7333b2f9, err_count = 0, comparisons = 0;
    accr_regs accr_regs_i (.*);
    accr_host accr_host_i (.*);
    initial forever #2.5 mclk = ~mclk;
    // bench model of the delay line, one entry per tick
    always @(posedge mclk) begin
        chk = !srst && mod_tick;
        hist = srst ? 256'h0 : mod_tick ? {hist[254:0], ch1_sample_in} : hist;
        exp_out = hist[m[64]];
    end
    // delay output checked, then free inputs changed
    always @(negedge mclk) begin
        if (chk) `CHK(ch1_sample_out, exp_out)
        shared_level_select <= 1'($random(seed));
        mod_tick <= 1'($random(seed));
        ch1_sample_in <= 1'($random(seed));
    end
    // bench model of one access; reserved codes keep the old field
    task automatic op(input logic w, input logic [7:0] p, a, d);
        logic hv;
        hv = p == 8'h00 && a >= 8'h3f && a <= 8'h42;
        accr_host_i.acc(w, p, a, d, q, h);
        if (w && hv && a == 8'h3f) m[63] = {d[7:4], 4'h0};
        if (w && hv && a == 8'h40) m[64] = d;
        if (w && hv && a == 8'h41) m[65] = {d[7], (d[6:5] == 2'h3) ? m[65][6:5] : d[6:5], d[4],
            (d[3:2] == 2'h3) ? m[65][3:2] : d[3:2], 1'b0, d[0]};
        if (w && hv && a == 8'h42 && d[7:2] <= 6'h2a) m[66] = {d[7:2], 2'h0};
        if (!w) `CHK({h, q}, {hv, hv ? m[a] : 8'h00})
        `CHK({ch1_gain_trim_code, 4'h0}, m[63])
        `CHK(ch1_gain_trim_tenths, 8'(m[63][7:4]) - 8'h08)
        `CHK(ch1_phase_delay_code, m[64])
        `CHK({ch2_input_kind, ch2_source_select, ch2_coupling_select, ch2_impedance_select, 1'b0,
            ch2_range_boost_enable}, m[65])
        `CHK({ch2_is_analog, ch2_coupling_select_coupled}, {m[65][6:5] != 2'h2, m[65][6:5] != 2'h2 && m[65][4]})
        `CHK({ch2_range_enhancer_on, ch2_auto_level_on},
            {m[65][0] && !shared_level_select, m[65][0] && shared_level_select})
        `CHK({ch2_analog_gain_code, 2'h0}, m[66])
    endtask : op
    // verdict and end of run
    task automatic conclude();
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // reset, reset-value reads, then random traffic with foreign pages and addresses
    initial begin
        {m[63], m[64], m[65], m[66]} = 32'h80000000;
        repeat (6) @(posedge mclk);
        @(negedge mclk) srst <= 1'b0;
        for (int i = 8'h3e; i < 8'h44; i++) op(1'b0, 8'h00, 8'(i), 8'h00);
        for (int i = 0; i < 600; i++)
            op(1'($random(seed)), ($random(seed) % 8 == 0) ? 8'h01 : 8'h00,
                8'h3e + 8'($unsigned($random(seed)) % 6), 8'($random(seed)));
        conclude();
    end
endmodule : testbench
